// ===== src/mps_core_regs.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module mps_core_regs #(
   parameter int STACK_DEPTH = mps_pkg::STACK_DEPTH_DEFAULT,
   parameter int ADDR_W      = 8
) (
   // Clock, reset, enable
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              clk_en,

   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,

   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,

   // Instruction stream from the decoder
   input  wire logic              instr_valid,
   input  wire mps_pkg::mps_op_t  instr_op,
   input  wire logic [10:0]       instr_operand,
   input  wire logic [7:0]        acc_value,
   output logic                   instr_ready,

   // Flag updates from the ALU and watchdog
   input  wire logic              alu_flags_we,
   input  wire logic              alu_zero,
   input  wire logic              alu_aux_carry,
   input  wire logic              alu_carry,
   input  wire logic              watchdog_timeout,

   // Data memory addressing
   input  wire logic [5:0]        data_addr,
   output logic [5:0]             resolved_addr,
   output logic [1:0]             bank_select,

   // Counter, table pointer, wake-up enables
   output logic [10:0]            program_counter,
   output logic                   page_select,
   output logic [7:0]             table_pointer_low_byte,
   output logic                   comparator2_wake_en,
   output logic                   port_change_wake_en,
   output logic                   adc_wake_en,
   output logic                   ext_pin_wake_en,
   output logic                   comparator1_wake_en,
   output logic                   comparator3_wake_en
);

   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   typedef struct packed {
      mps_pkg::mps_state_t              st;
      logic [3:0]                       div_cnt;
      logic [10:0]                      pc;
      logic [STACK_DEPTH-1:0][10:0]     stk;
      logic [SP_W-1:0]                  sp;
      logic [7:0]                       status;
      logic [7:0]                       ram_select_reg;
      logic [7:0]                       table_low;
      logic [7:0]                       wake;
      logic [1:0]                       div_sel;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             rvalid;
      logic [1:0]                       rresp;
      logic [31:0]                      rdata;
   } mps_regs_t;

   mps_regs_t state_reg;
   mps_regs_t state_next;

   logic        cycle_tick;
   logic [3:0]  div_limit;
   logic        wr_go;
   logic        rd_go;
   logic [5:0]  wr_idx;
   logic [5:0]  rd_idx;
   logic [10:0] pc_plus;
   logic [10:0] top_entry;

   // The instruction cycle runs at mclk divided by 2, 4, 8 or 16.
   assign div_limit  = 4'((5'h02 << state_reg.div_sel) - 5'h01);
   assign cycle_tick = clk_en && (state_reg.div_cnt == div_limit);
   assign pc_plus    = state_reg.pc + 11'h001;
   assign top_entry  = state_reg.stk[SP_W'(state_reg.sp - SP_W'(1))];

   // An instruction is taken only on a tick and never during the flush cycle.
   assign instr_ready = cycle_tick && (state_reg.st == mps_pkg::ST_RUN);

   assign s_axi_awready = clk_en && !state_reg.bvalid && s_axi_awvalid && s_axi_wvalid;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = clk_en && !state_reg.rvalid && s_axi_arvalid;
   assign wr_go  = s_axi_awready;
   assign rd_go  = s_axi_arready;
   assign wr_idx = s_axi_awaddr[7:2];
   assign rd_idx = s_axi_araddr[7:2];

   always_comb begin
      state_next = state_reg;

      // Bus write, applied first so core events below take priority.
      if (s_axi_bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         state_next.bvalid = 1'b1;
         state_next.bresp  = mps_pkg::RESP_OKAY;
         case (wr_idx)
            mps_pkg::IDX_PC_LOW: begin
               if (s_axi_wstrb[0]) begin
                  state_next.pc[7:0] = s_axi_wdata[7:0];
               end
            end
            mps_pkg::IDX_STATUS: begin
               if (s_axi_wstrb[0]) begin
                  state_next.status[2:0] = s_axi_wdata[2:0];
               end
            end
            mps_pkg::IDX_RAM_SELECT: begin
               if (s_axi_wstrb[0]) begin
                  state_next.ram_select_reg = s_axi_wdata[7:0];
               end
            end
            mps_pkg::IDX_TABLE_LOW: begin
               if (s_axi_wstrb[0]) begin
                  state_next.table_low = s_axi_wdata[7:0];
               end
            end
            mps_pkg::IDX_WAKE_ENABLE: begin
               if (s_axi_wstrb[0]) begin
                  state_next.wake = s_axi_wdata[7:0] & mps_pkg::WAKE_MASK;
               end
            end
            mps_pkg::IDX_CLOCK_DIV: begin
               if (s_axi_wstrb[0]) begin
                  state_next.div_sel = s_axi_wdata[1:0];
               end
            end
            mps_pkg::IDX_STACK_PTR: begin
               state_next.bresp = mps_pkg::RESP_SLVERR;
            end
            default: begin
               state_next.bresp = mps_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Bus read.
      if (s_axi_rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
      if (rd_go) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = mps_pkg::RESP_OKAY;
         state_next.rdata  = 32'h0000_0000;
         case (rd_idx)
            mps_pkg::IDX_PC_LOW: begin
               state_next.rdata[7:0] = state_reg.pc[7:0];
            end
            mps_pkg::IDX_STATUS: begin
               state_next.rdata[7:0] = state_reg.status & mps_pkg::STATUS_MASK;
            end
            mps_pkg::IDX_RAM_SELECT: begin
               state_next.rdata[7:0] = state_reg.ram_select_reg;
            end
            mps_pkg::IDX_TABLE_LOW: begin
               state_next.rdata[7:0] = state_reg.table_low;
            end
            mps_pkg::IDX_WAKE_ENABLE: begin
               state_next.rdata[7:0] = state_reg.wake & mps_pkg::WAKE_MASK;
            end
            mps_pkg::IDX_CLOCK_DIV: begin
               state_next.rdata[1:0] = state_reg.div_sel;
            end
            mps_pkg::IDX_STACK_PTR: begin
               state_next.rdata[SP_W-1:0] = state_reg.sp;
            end
            default: begin
               state_next.rresp = mps_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Instruction cycle divider.
      if (cycle_tick) begin
         state_next.div_cnt = mps_pkg::DIV_CNT_RESET;
      end else begin
         state_next.div_cnt = state_reg.div_cnt + 4'h1;
      end

      // Sequencing.
      case (state_reg.st)
         mps_pkg::ST_RUN: begin
            if (instr_ready && instr_valid) begin
               state_next.pc = pc_plus;
               case (instr_op)
                  mps_pkg::OP_SHORT_JUMP: begin
                     // Page bit stays, so the target lies in the current 1K page.
                     state_next.pc = {state_reg.pc[10], instr_operand[9:0]};
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_SHORT_CALL: begin
                     state_next.pc = {state_reg.pc[10], instr_operand[9:0]};
                     state_next.stk[state_reg.sp] = pc_plus;
                     state_next.sp = SP_W'(state_reg.sp + SP_W'(1));
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_LONG_JUMP: begin
                     state_next.pc = instr_operand;
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_LONG_CALL: begin
                     state_next.pc = instr_operand;
                     state_next.stk[state_reg.sp] = pc_plus;
                     state_next.sp = SP_W'(state_reg.sp + SP_W'(1));
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_RETURN,
                  mps_pkg::OP_RETURN_LIT,
                  mps_pkg::OP_RETURN_INT: begin
                     // The stack is circular: underflow wraps, as on the real part.
                     state_next.pc = top_entry;
                     state_next.sp = SP_W'(state_reg.sp - SP_W'(1));
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_ADD_PC: begin
                     state_next.pc = pc_plus + {3'h0, acc_value};
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_MOVE_PC: begin
                     state_next.pc = {state_reg.pc[10:8], acc_value};
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_WRITE_PC: begin
                     state_next.pc = {state_reg.pc[10:8], instr_operand[7:0]};
                     state_next.st = mps_pkg::ST_FLUSH;
                  end
                  mps_pkg::OP_SLEEP: begin
                     state_next.status[mps_pkg::BIT_POWERDOWN] = 1'b0;
                  end
                  default: begin
                  end
               endcase
            end
         end
         mps_pkg::ST_FLUSH: begin
            if (cycle_tick) begin
               state_next.st = mps_pkg::ST_RUN;
            end
         end
         default: begin
            state_next.st = mps_pkg::ST_RUN;
         end
      endcase

      // Flags: time-out clears first, so a same-cycle set wins.
      if (clk_en && watchdog_timeout) begin
         state_next.status[mps_pkg::BIT_TIMEOUT] = 1'b0;
      end
      if (instr_ready && instr_valid) begin
         if (instr_op == mps_pkg::OP_SLEEP || instr_op == mps_pkg::OP_WATCHDOG_CLR) begin
            state_next.status[mps_pkg::BIT_TIMEOUT] = 1'b1;
         end
         if (instr_op == mps_pkg::OP_WATCHDOG_CLR) begin
            state_next.status[mps_pkg::BIT_POWERDOWN] = 1'b1;
         end
      end
      if (clk_en && alu_flags_we) begin
         state_next.status[mps_pkg::BIT_ZERO]      = alu_zero;
         state_next.status[mps_pkg::BIT_AUX_CARRY] = alu_aux_carry;
         state_next.status[mps_pkg::BIT_CARRY]     = alu_carry;
      end
      state_next.status[7:5] = 3'h0;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg                <= '0;
         state_reg.st             <= mps_pkg::ST_RUN;
         state_reg.pc             <= mps_pkg::PC_RESET;
         state_reg.status         <= mps_pkg::BYTE_RESET;
         // Reset stands for power-up, so both time-out and power-down start set.
         state_reg.status[mps_pkg::BIT_TIMEOUT]   <= 1'b1;
         state_reg.status[mps_pkg::BIT_POWERDOWN] <= 1'b1;
         state_reg.ram_select_reg <= mps_pkg::BYTE_RESET;
         state_reg.table_low      <= mps_pkg::BYTE_RESET;
         state_reg.wake           <= mps_pkg::BYTE_RESET;
         state_reg.div_sel        <= mps_pkg::DIV_RESET;
         state_reg.div_cnt        <= mps_pkg::DIV_CNT_RESET;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // The indirect location holds nothing; it is redirected to the select address.
   assign resolved_addr = (data_addr == 6'h00) ? state_reg.ram_select_reg[5:0]
                                                : data_addr;
   assign bank_select   = state_reg.ram_select_reg[7:6];

   assign program_counter        = state_reg.pc;
   assign page_select            = state_reg.pc[mps_pkg::PAGE_W];
   assign table_pointer_low_byte = state_reg.table_low;
   assign comparator2_wake_en    = state_reg.wake[mps_pkg::BIT_CMP2_WAKE];
   assign comparator1_wake_en    = state_reg.wake[mps_pkg::BIT_CMP1_WAKE];
   assign comparator3_wake_en    = state_reg.wake[mps_pkg::BIT_CMP3_WAKE];
   assign port_change_wake_en    = state_reg.wake[mps_pkg::BIT_PORT_WAKE];
   assign ext_pin_wake_en        = state_reg.wake[mps_pkg::BIT_EXT_WAKE];
   // Software must set this before relying on ADC completion during sleep.
   assign adc_wake_en            = state_reg.wake[mps_pkg::BIT_ADC_WAKE];

   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp  = state_reg.bresp;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rresp  = state_reg.rresp;
   assign s_axi_rdata  = state_reg.rdata;

endmodule : mps_core_regs

`default_nettype wire

// ===== src/mps_pkg.sv
package mps_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [5:0] IDX_PC_LOW      = 6'h02;
   localparam logic [5:0] IDX_STATUS      = 6'h03;
   localparam logic [5:0] IDX_RAM_SELECT  = 6'h04;
   localparam logic [5:0] IDX_TABLE_LOW   = 6'h09;
   localparam logic [5:0] IDX_WAKE_ENABLE = 6'h0a;
   localparam logic [5:0] IDX_CLOCK_DIV   = 6'h10;
   localparam logic [5:0] IDX_STACK_PTR   = 6'h11;

   // Field positions.
   localparam int BIT_TIMEOUT   = 4;
   localparam int BIT_POWERDOWN = 3;
   localparam int BIT_ZERO      = 2;
   localparam int BIT_AUX_CARRY = 1;
   localparam int BIT_CARRY     = 0;
   localparam int BIT_CMP2_WAKE = 7;
   localparam int BIT_PORT_WAKE = 6;
   localparam int BIT_ADC_WAKE  = 5;
   localparam int BIT_EXT_WAKE  = 4;
   localparam int BIT_CMP1_WAKE = 2;
   localparam int BIT_CMP3_WAKE = 1;

   // Masks of implemented bits; bits outside read as zero.
   localparam logic [7:0] WAKE_MASK   = 8'hf6;
   localparam logic [7:0] STATUS_MASK = 8'h1f;

   // Widths and paging.
   localparam int PC_W     = 11;
   localparam int PAGE_W   = 10;
   localparam int STACK_DEPTH_DEFAULT = 8;

   // Values after reset.
   localparam logic [10:0] PC_RESET    = 11'h000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [1:0]  DIV_RESET   = 2'h0;
   localparam logic [3:0]  DIV_CNT_RESET = 4'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_FLUSH = 2'b10
   } mps_state_t;

   typedef enum logic [3:0] {
      OP_ADVANCE       = 4'h0,
      OP_SHORT_JUMP    = 4'h1,
      OP_SHORT_CALL    = 4'h2,
      OP_LONG_JUMP     = 4'h3,
      OP_LONG_CALL     = 4'h4,
      OP_RETURN        = 4'h5,
      OP_RETURN_LIT    = 4'h6,
      OP_RETURN_INT    = 4'h7,
      OP_ADD_PC        = 4'h8,
      OP_MOVE_PC       = 4'h9,
      OP_WRITE_PC      = 4'ha,
      OP_SLEEP         = 4'hb,
      OP_WATCHDOG_CLR  = 4'hc
   } mps_op_t;

endpackage : mps_pkg

// ===== verif/mcu_pc_status_bank_wake_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end

module mcu_pc_status_bank_wake_regs_tb;
   logic mclk = 1'h0, reset = 1'h1, clk_en = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, acc_value = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, instr_valid = 1'h0;
   logic alu_flags_we = 1'h0, alu_zero = 1'h0, alu_aux_carry = 1'h0, alu_carry = 1'h0;
   logic watchdog_timeout = 1'h0;
   logic [10:0] instr_operand = 11'h000, program_counter;
   logic [5:0] data_addr = 6'h00, resolved_addr;
   mps_pkg::mps_op_t instr_op = mps_pkg::OP_ADVANCE;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, bank_select;
   logic instr_ready, page_select, comparator2_wake_en, port_change_wake_en, adc_wake_en;
   logic ext_pin_wake_en, comparator1_wake_en, comparator3_wake_en;
   logic [7:0] table_pointer_low_byte;
   int err_count = 0;
   int n_checks = 0;

   mps_core_regs i_dut (
      .mclk, .reset, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .instr_valid, .instr_op, .instr_operand, .acc_value,
      .instr_ready, .alu_flags_we, .alu_zero, .alu_aux_carry, .alu_carry, .watchdog_timeout,
      .data_addr, .resolved_addr, .bank_select, .program_counter, .page_select,
      .table_pointer_low_byte, .comparator2_wake_en, .port_change_wake_en, .adc_wake_en,
      .ext_pin_wake_en, .comparator1_wake_en, .comparator3_wake_en
   );

   always #2.5 mclk = ~mclk;

   task automatic end_of_test;
      $display("Checks: %0d  Mismatches: %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic guard(inout int n);
      n++;
      if (n > 300) begin
         err_count++;
         $display("MISMATCH at %0t: wait timed out", $time);
         end_of_test();
      end
   endtask : guard

   // Ready is combinational, so it is judged at the falling edge where nothing moves.
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'(d);
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin @(negedge mclk); guard(n); end while (!s_axi_awready);
      `CHK(s_axi_wready, 1'h1)
      @(posedge mclk);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do begin @(negedge mclk); guard(n); end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, er)
      @(posedge mclk);
      s_axi_bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int n = 0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin @(negedge mclk); guard(n); end while (!s_axi_arready);
      @(posedge mclk);
      s_axi_arvalid <= 1'h0;
      do begin @(negedge mclk); guard(n); end while (!s_axi_rvalid);
      `CHK(s_axi_rdata, 32'(e))
      `CHK(s_axi_rresp, er)
      @(posedge mclk);
      s_axi_rready <= 1'h0;
   endtask : axi_rd

   task automatic exec(input mps_pkg::mps_op_t o, input logic [10:0] x, input logic [7:0] a);
      int n = 0;
      @(posedge mclk);
      instr_valid <= 1'h1;
      instr_op <= o;
      instr_operand <= x;
      acc_value <= a;
      do begin @(negedge mclk); guard(n); end while (!instr_ready);
      @(posedge mclk);
      instr_valid <= 1'h0;
      @(negedge mclk);
   endtask : exec

   task automatic t_regs;
      logic [7:0] w;
      logic [7:0] en;
      axi_rd(8'h08, 8'h00, 2'h0);
      axi_rd(8'h10, 8'h00, 2'h0);
      axi_rd(8'h24, 8'h00, 2'h0);
      axi_rd(8'h3c, 8'h00, 2'h2);
      axi_wr(8'h44, 8'h01, 2'h2);
      axi_wr(8'h10, 8'hc5, 2'h0);
      `CHK(bank_select, 2'h3)
      data_addr <= 6'h00;
      @(negedge mclk);
      `CHK(resolved_addr, 6'h05)
      @(posedge mclk);
      data_addr <= 6'h21;
      @(negedge mclk);
      `CHK(resolved_addr, 6'h21)
      axi_rd(8'h10, 8'hc5, 2'h0);
      axi_wr(8'h24, 8'ha5, 2'h0);
      `CHK(table_pointer_low_byte, 8'ha5)
      // A write with lane 0 disabled is answered but must leave the byte alone.
      s_axi_wstrb <= 4'h0;
      axi_wr(8'h24, 8'h5a, 2'h0);
      `CHK(table_pointer_low_byte, 8'ha5)
      s_axi_wstrb <= 4'h1;
      for (int i = 0; i < 8; i++) begin
         w = 8'h01 << i;
         axi_wr(8'h28, w, 2'h0);
         axi_rd(8'h28, w & 8'hf6, 2'h0);
         en = {comparator2_wake_en, port_change_wake_en, adc_wake_en, ext_pin_wake_en,
               1'h0, comparator1_wake_en, comparator3_wake_en, 1'h0};
         `CHK(en, w & 8'hf6)
         `CHK(adc_wake_en, w[5])
      end
   endtask : t_regs

   task automatic t_status;
      axi_rd(8'h0c, 8'h18, 2'h0);
      exec(mps_pkg::OP_SLEEP, 11'h000, 8'h00);
      axi_rd(8'h0c, 8'h10, 2'h0);
      @(posedge mclk);
      watchdog_timeout <= 1'h1;
      @(posedge mclk);
      watchdog_timeout <= 1'h0;
      axi_rd(8'h0c, 8'h00, 2'h0);
      exec(mps_pkg::OP_WATCHDOG_CLR, 11'h000, 8'h00);
      axi_rd(8'h0c, 8'h18, 2'h0);
      @(posedge mclk);
      alu_flags_we <= 1'h1;
      alu_zero <= 1'h1;
      alu_carry <= 1'h1;
      @(posedge mclk);
      alu_flags_we <= 1'h0;
      axi_rd(8'h0c, 8'h1d, 2'h0);
      axi_wr(8'h0c, 8'hfe, 2'h0);
      axi_rd(8'h0c, 8'h1e, 2'h0);
   endtask : t_status

   task automatic t_jumps;
      exec(mps_pkg::OP_LONG_JUMP, 11'h5a5, 8'h00);
      `CHK(program_counter, 11'h5a5)
      `CHK(page_select, 1'h1)
      exec(mps_pkg::OP_SHORT_JUMP, 11'h0f0, 8'h00);
      `CHK(program_counter, 11'h4f0)
      exec(mps_pkg::OP_MOVE_PC, 11'h000, 8'h33);
      `CHK(program_counter, 11'h433)
      exec(mps_pkg::OP_ADD_PC, 11'h000, 8'hff);
      `CHK(program_counter, 11'h533)
      axi_wr(8'h08, 8'hc3, 2'h0);
      `CHK(program_counter, 11'h5c3)
      exec(mps_pkg::OP_WRITE_PC, 11'h7aa, 8'h00);
      `CHK(program_counter, 11'h5aa)
      // With the enable low a waiting instruction must not be taken.
      @(posedge mclk);
      clk_en <= 1'h0;
      instr_valid <= 1'h1;
      repeat (20) @(negedge mclk);
      `CHK(instr_ready, 1'h0)
      `CHK(program_counter, 11'h5aa)
      @(posedge mclk);
      clk_en <= 1'h1;
      instr_valid <= 1'h0;
      exec(mps_pkg::OP_LONG_JUMP, 11'h7ff, 8'h00);
      exec(mps_pkg::OP_ADD_PC, 11'h000, 8'h01);
      `CHK(program_counter, 11'h001)
   endtask : t_jumps

   // Nested calls then returns check both the pushed values and their order.
   task automatic t_calls;
      mps_pkg::mps_op_t r[3];
      r = '{mps_pkg::OP_RETURN, mps_pkg::OP_RETURN_LIT, mps_pkg::OP_RETURN_INT};
      exec(mps_pkg::OP_LONG_JUMP, 11'h100, 8'h00);
      for (int i = 0; i < 3; i++) begin
         exec(mps_pkg::OP_LONG_CALL, 11'h6ab, 8'h00);
         `CHK(program_counter, 11'h6ab)
         exec(mps_pkg::OP_SHORT_CALL, 11'h012, 8'h00);
         `CHK(program_counter, 11'h412)
         exec(r[i], 11'h000, 8'h00);
         `CHK(program_counter, 11'h6ac)
         exec(r[i], 11'h000, 8'h00);
         `CHK(program_counter, 11'h101 + 11'(i))
      end
   endtask : t_calls

   task automatic t_timing;
      int n;
      for (int d = 0; d < 4; d++) begin
         axi_wr(8'h40, 8'(d), 2'h0);
         exec(mps_pkg::OP_ADVANCE, 11'h000, 8'h00);
         n = 0;
         do begin @(negedge mclk); n++; end while (!instr_ready && n < 100);
         `CHK(n, (2 << d) - 1)
         exec(mps_pkg::OP_LONG_JUMP, 11'h2a0, 8'h00);
         n = 0;
         do begin @(negedge mclk); n++; end while (!instr_ready && n < 100);
         `CHK(n, (4 << d) - 1)
      end
      axi_wr(8'h40, 8'h00, 2'h0);
   endtask : t_timing

   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'h0;
      @(negedge mclk);
      `CHK(program_counter, 11'h000)
      t_regs();
      t_status();
      t_jumps();
      t_calls();
      t_timing();
      @(posedge mclk);
      reset <= 1'h1;
      @(posedge mclk);
      reset <= 1'h0;
      @(negedge mclk);
      `CHK(program_counter, 11'h000)
      axi_rd(8'h0c, 8'h18, 2'h0);
      end_of_test();
   end
endmodule : mcu_pc_status_bank_wake_regs_tb

`default_nettype wire

// ===== verif/mps_core_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

module mps_core_regs_checker (
   // Clock and reset
   input wire logic             mclk,
   input wire logic             reset,
   // Instruction stream
   input wire logic             instr_valid,
   input wire logic             instr_ready,
   input wire mps_pkg::mps_op_t instr_op,
   input wire logic [10:0]      instr_operand,
   input wire logic [7:0]       acc_value,
   // Counter and addressing
   input wire logic [10:0]      program_counter,
   input wire logic             page_select,
   input wire logic [5:0]       data_addr,
   input wire logic [5:0]       resolved_addr
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   logic        take;
   logic [10:0] pc_q;
   logic [10:0] opnd_q;
   logic [7:0]  acc_q;

   assign take = instr_valid && instr_ready;

   // Copies of the inputs one edge back, so slices of old values stay simple.
   always_ff @(posedge mclk) begin
      pc_q   <= program_counter;
      opnd_q <= instr_operand;
      acc_q  <= acc_value;
   end

   pc_reset_zero_a: assert property ($fell(reset) |-> program_counter == 11'h000)
      else $error("Counter not zero after reset.");
   long_jump_load_a: assert property (
      take && instr_op == mps_pkg::OP_LONG_JUMP |=> program_counter == $past(instr_operand))
      else $error("Long jump target not loaded.");
   long_call_load_a: assert property (
      take && instr_op == mps_pkg::OP_LONG_CALL |=> program_counter == opnd_q)
      else $error("Long call target not loaded.");
   short_jump_page_a: assert property (
      take && instr_op == mps_pkg::OP_SHORT_JUMP |=> program_counter == {pc_q[10], opnd_q[9:0]})
      else $error("Short jump changed the page bit.");
   move_low_byte_a: assert property (
      take && instr_op == mps_pkg::OP_MOVE_PC |=> program_counter == {pc_q[10:8], acc_q})
      else $error("Move to counter touched upper bits.");
   add_carry_up_a: assert property (
      take && instr_op == mps_pkg::OP_ADD_PC
      |=> program_counter == pc_q + 11'h001 + {3'h0, acc_q})
      else $error("Add to counter lost the carry.");
   flush_slot_a: assert property (
      take && (instr_op == mps_pkg::OP_SHORT_JUMP || instr_op == mps_pkg::OP_ADD_PC)
      |=> !instr_ready [*3])
      else $error("No extra cycle after a counter change.");
   page_bit_a: assert property (page_select == program_counter[10])
      else $error("Page output differs from counter top bit.");
   direct_addr_a: assert property (
      data_addr != 6'h00 |-> resolved_addr == data_addr)
      else $error("Direct address was redirected.");

   cover property (take && instr_op == mps_pkg::OP_LONG_CALL);
   cover property (take && instr_op == mps_pkg::OP_RETURN_INT);
   cover property (take && instr_op == mps_pkg::OP_ADD_PC);
endmodule : mps_core_regs_checker

bind mps_core_regs mps_core_regs_checker i_chk (
   .mclk, .reset, .instr_valid, .instr_ready, .instr_op, .instr_operand, .acc_value,
   .program_counter, .page_select, .data_addr, .resolved_addr
);

`default_nettype wire
